// *** modulo_timer_pkg.sv ***
// Package with register map, field layout, reset values and carrier types of the 8-bit modulo timer.
package modulo_timer_pkg;

    // Register word addresses on the plain register port.
    localparam logic [7:0] ADDR_TIMER_STATUS_CONTROL = 8'h00;
    localparam logic [7:0] ADDR_TIMER_CLOCK_CONFIG = 8'h01;
    localparam logic [7:0] ADDR_COUNT_VALUE = 8'h02;
    localparam logic [7:0] ADDR_MODULO_VALUE = 8'h03;

    // Status and control field positions.
    localparam int OVERFLOW_FLAG_BIT = 7;
    localparam int OVERFLOW_IRQ_ENABLE_BIT = 6;
    localparam int COUNTER_RESET_BIT = 5;
    localparam int COUNTER_STOP_BIT = 4;

    // Clock configuration field positions.
    localparam int CLOCK_SOURCE_SELECT_MSB = 5;
    localparam int CLOCK_SOURCE_SELECT_LSB = 4;
    localparam int PRESCALE_SELECT_MSB = 3;
    localparam int PRESCALE_SELECT_LSB = 0;

    // Clock source encodings.
    localparam logic [1:0] SOURCE_BUS_CLOCK = 2'h0;
    localparam logic [1:0] SOURCE_FIXED_FREQ_CLOCK = 2'h1;
    localparam logic [1:0] SOURCE_PIN_FALLING = 2'h2;
    localparam logic [1:0] SOURCE_PIN_RISING = 2'h3;

    // Prescale codes 0 to 8 give divide by 2 to the power of the code.
    localparam logic [3:0] PRESCALE_LARGEST_CODE = 4'h8;

    // Reset values.
    localparam logic [7:0] RESET_COUNT_VALUE = 8'h00;
    localparam logic [7:0] RESET_MODULO_VALUE = 8'h00;
    localparam logic [1:0] RESET_CLOCK_SOURCE_SELECT = SOURCE_BUS_CLOCK;
    localparam logic [3:0] RESET_PRESCALE_SELECT = 4'h0;
    localparam logic RESET_COUNTER_STOP = 1'b1;
    localparam logic [7:0] COUNT_MAXIMUM = 8'hFF;
    localparam logic [7:0] MODULO_FREE_RUNNING = 8'h00;
    localparam logic [7:0] READ_IDLE_VALUE = 8'h00;

    // One register port request.
    typedef struct packed {
        logic [7:0] address;
        logic [7:0] writeData;
        logic write;
        logic read;
    } bus_request_type;

    // Timer pins sampled from outside the clock domain.
    typedef struct packed {
        logic externalTimerClockPin;
        logic fixedFreqClock;
    } timer_pins_type;

endpackage

// *** timer_tick_source.sv ***
// Clock source selector, pin synchronisers and nine-tap prescaler of the modulo timer.
`timescale 1ns/100ps
module timer_tick_source
    import modulo_timer_pkg::*;
(
    // Clock and reset.
    input wire logic clock,
    input wire logic rst,
    // Configuration from the register file.
    input wire logic [1:0] clockSourceSelect,
    input wire logic [3:0] prescaleSelect,
    input wire logic running,
    // Asynchronous timer pins.
    input wire timer_pins_type pins,
    // One-cycle count enable.
    output logic countTick
);

    typedef struct packed {
        logic [1:0] pinSync;
        logic pinPrevious;
        logic [1:0] fixedSync;
        logic fixedPrevious;
        logic [7:0] prescaleCount;
    } tick_state_type;

    tick_state_type state;
    tick_state_type next_state;
    logic sourceTick;
    logic [7:0] tapMask;

    // Codes above the largest listed code fall back to the widest divider.
    function automatic logic [7:0] prescale_mask(input logic [3:0] code);
        logic [3:0] used;
        used = (code > PRESCALE_LARGEST_CODE) ? PRESCALE_LARGEST_CODE : code;
        prescale_mask = 8'(9'h1FF >> (4'h9 - used));
    endfunction

    always_comb
    begin
        next_state = state;
        // Only the second stage of each synchroniser feeds the edge detectors.
        next_state.pinSync = {state.pinSync[0], pins.externalTimerClockPin};
        next_state.pinPrevious = state.pinSync[1];
        next_state.fixedSync = {state.fixedSync[0], pins.fixedFreqClock};
        next_state.fixedPrevious = state.fixedSync[1];
        case (clockSourceSelect)
            SOURCE_BUS_CLOCK: sourceTick = 1'b1;
            SOURCE_FIXED_FREQ_CLOCK: sourceTick = state.fixedSync[1] & ~state.fixedPrevious;
            SOURCE_PIN_FALLING: sourceTick = ~state.pinSync[1] & state.pinPrevious;
            default: sourceTick = state.pinSync[1] & ~state.pinPrevious;
        endcase
        tapMask = prescale_mask(prescaleSelect);
        countTick = running && sourceTick && ((state.prescaleCount & tapMask) == tapMask);
        // The prescaler is held at zero while stopped so a restart begins a whole period.
        if (!running)
        begin
            next_state.prescaleCount = 8'h00;
        end
        else if (sourceTick)
        begin
            next_state.prescaleCount = state.prescaleCount + 8'h01;
        end
    end

    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            state <= '0;
        end
        else
        begin
            state <= next_state;
        end
    end

endmodule

// *** modulo_timer.sv ***
// Top of the 8-bit modulo timer: register file, counter, overflow flag and interrupt request.
`timescale 1ns/100ps
//
// Operation
// - Three modes: stopped, free-running, modulo; stopped after reset until software starts it.
// - Running with nonzero modulo is modulo mode; zero modulo is free-running.
// - Reset clears count and modulo, selects bus clock and divide by one.
// - Writing status/control with stop bit clear starts counting.
// - Four count sources: bus clock, fixed clock, pin falling or rising edge.
// - Changing source while running keeps the count and continues.
// - Divide by 1 to 256 in powers of two; divisor change keeps the count.
// - Modulo 01 to FF is the compare value; zero means free-running.
// - Count increments at prescaled rate to modulo (FF when free-running), then wraps to zero.
// - Overflow flag sets when count goes from modulo value (FF when free-running) to zero.
// - Modulo write while running zeroes the count and clears the flag.
// - Writing zero to the flag clears it only after a read with flag set.
// - An overflow between read and write restarts the clearing sequence.
// - Writing one to counter reset or any modulo write clears the flag.
// - Interrupt request is flag and interrupt enable together.
// - Source field bits 5:4: bus, fixed, pin falling, pin rising.
// - Prescale field bits 3:0: codes 0 to 8 select 1 to 256, others 256.
// - Counter reset bit zeroes the count, is write-only and reads zero.
// - Stop bit freezes the count, clearing resumes; count register ignores writes.
module modulo_timer
    import modulo_timer_pkg::*;
(
    // Clock and reset.
    input wire logic clock,
    input wire logic rst,
    // Register port.
    input wire bus_request_type busRequest,
    output logic [7:0] readData,
    // Timer pins.
    input wire timer_pins_type pins,
    // Interrupt request.
    output logic overflowIrq
);

    typedef struct packed {
        logic [7:0] countValue;
        logic [7:0] moduloValue;
        logic counterStop;
        logic overflowIrqEnable;
        logic [1:0] clockSourceSelect;
        logic [3:0] prescaleSelect;
        logic overflowFlag;
        logic clearArmed;
        logic [7:0] readData;
    } timer_state_type;

    localparam timer_state_type RESET_STATE = '{
        countValue: RESET_COUNT_VALUE,
        moduloValue: RESET_MODULO_VALUE,
        counterStop: RESET_COUNTER_STOP,
        overflowIrqEnable: 1'b0,
        clockSourceSelect: RESET_CLOCK_SOURCE_SELECT,
        prescaleSelect: RESET_PRESCALE_SELECT,
        overflowFlag: 1'b0,
        clearArmed: 1'b0,
        readData: READ_IDLE_VALUE
    };

    timer_state_type state;
    timer_state_type next_state;
    logic countTick;
    logic counterReset;
    logic moduloWrite;
    logic clearRequest;
    logic atTop;
    logic overflowEvent;

    timer_tick_source tickSource
    (
        .clock(clock),
        .rst(rst),
        .clockSourceSelect(state.clockSourceSelect),
        .prescaleSelect(state.prescaleSelect),
        .running(!state.counterStop),
        .pins(pins),
        .countTick(countTick)
    );

    always_comb
    begin
        next_state = state;
        counterReset = 1'b0;
        moduloWrite = 1'b0;
        clearRequest = 1'b0;
        overflowEvent = 1'b0;
        // Read data stand only in the cycle after the read strobe.
        next_state.readData = READ_IDLE_VALUE;

        if (busRequest.read)
        begin
            if (busRequest.address == ADDR_TIMER_STATUS_CONTROL)
            begin
                next_state.readData[OVERFLOW_FLAG_BIT] = state.overflowFlag;
                next_state.readData[OVERFLOW_IRQ_ENABLE_BIT] = state.overflowIrqEnable;
                next_state.readData[COUNTER_RESET_BIT] = 1'b0;
                next_state.readData[COUNTER_STOP_BIT] = state.counterStop;
                // First step of the clearing sequence.
                if (state.overflowFlag)
                begin
                    next_state.clearArmed = 1'b1;
                end
            end
            else if (busRequest.address == ADDR_TIMER_CLOCK_CONFIG)
            begin
                next_state.readData[CLOCK_SOURCE_SELECT_MSB:CLOCK_SOURCE_SELECT_LSB] = state.clockSourceSelect;
                next_state.readData[PRESCALE_SELECT_MSB:PRESCALE_SELECT_LSB] = state.prescaleSelect;
            end
            else if (busRequest.address == ADDR_COUNT_VALUE)
            begin
                next_state.readData = state.countValue;
            end
            else if (busRequest.address == ADDR_MODULO_VALUE)
            begin
                next_state.readData = state.moduloValue;
            end
        end

        if (busRequest.write)
        begin
            if (busRequest.address == ADDR_TIMER_STATUS_CONTROL)
            begin
                next_state.overflowIrqEnable = busRequest.writeData[OVERFLOW_IRQ_ENABLE_BIT];
                next_state.counterStop = busRequest.writeData[COUNTER_STOP_BIT];
                counterReset = busRequest.writeData[COUNTER_RESET_BIT];
                // Second step: a zero written to the flag after an armed read.
                clearRequest = state.clearArmed && !busRequest.writeData[OVERFLOW_FLAG_BIT];
                next_state.clearArmed = 1'b0;
            end
            else if (busRequest.address == ADDR_TIMER_CLOCK_CONFIG)
            begin
                // The count is left alone so counting continues with the new setting.
                next_state.clockSourceSelect =
                    busRequest.writeData[CLOCK_SOURCE_SELECT_MSB:CLOCK_SOURCE_SELECT_LSB];
                next_state.prescaleSelect = busRequest.writeData[PRESCALE_SELECT_MSB:PRESCALE_SELECT_LSB];
            end
            else if (busRequest.address == ADDR_MODULO_VALUE)
            begin
                next_state.moduloValue = busRequest.writeData;
                moduloWrite = 1'b1;
            end
            // Writes to the count register have no effect.
        end

        // Zero modulo wraps at the top of the range, otherwise at the modulo value.
        if (state.moduloValue == MODULO_FREE_RUNNING)
        begin
            atTop = state.countValue == COUNT_MAXIMUM;
        end
        else
        begin
            atTop = state.countValue == state.moduloValue;
        end

        // A counter reset or modulo write in the same cycle as a tick wins, so no overflow is seen.
        if (counterReset || moduloWrite)
        begin
            next_state.countValue = RESET_COUNT_VALUE;
            next_state.overflowFlag = 1'b0;
            next_state.clearArmed = 1'b0;
        end
        else
        begin
            if (!state.counterStop && countTick)
            begin
                if (atTop)
                begin
                    next_state.countValue = RESET_COUNT_VALUE;
                    overflowEvent = 1'b1;
                end
                else
                begin
                    next_state.countValue = state.countValue + 8'h01;
                end
            end
            if (overflowEvent)
            begin
                // A fresh overflow sets the flag and disarms any pending clear.
                next_state.overflowFlag = 1'b1;
                next_state.clearArmed = 1'b0;
            end
            else if (clearRequest)
            begin
                next_state.overflowFlag = 1'b0;
            end
        end
    end

    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            state <= RESET_STATE;
        end
        else
        begin
            state <= next_state;
        end
    end

    assign readData = state.readData;
    // Software must not enable this while the flag is set, or it fires at once.
    assign overflowIrq = state.overflowFlag && state.overflowIrqEnable;

endmodule

// *** modulo_timer_monitor.sv ***
// Checker of the modulo timer register port and interrupt request.
`timescale 1ns/100ps
module modulo_timer_monitor
    import modulo_timer_pkg::*;
(
    // Clock and reset.
    input wire logic clock,
    input wire logic rst,
    // Watched ports.
    input wire bus_request_type busRequest,
    input wire logic [7:0] readData,
    input wire logic overflowIrq
);
    default clocking @(posedge clock); endclocking
    default disable iff (rst);
    logic rdSc, wrSc, wrMod, rdMod, wrCfg, rdCfg;
    assign rdSc = busRequest.read && busRequest.address == ADDR_TIMER_STATUS_CONTROL;
    assign wrSc = busRequest.write && busRequest.address == ADDR_TIMER_STATUS_CONTROL;
    assign rdMod = busRequest.read && busRequest.address == ADDR_MODULO_VALUE;
    assign wrMod = busRequest.write && busRequest.address == ADDR_MODULO_VALUE;
    assign rdCfg = busRequest.read && busRequest.address == ADDR_TIMER_CLOCK_CONFIG;
    assign wrCfg = busRequest.write && busRequest.address == ADDR_TIMER_CLOCK_CONFIG;
    a_read_idle: assert property (!$past(busRequest.read) |-> readData == READ_IDLE_VALUE)
        else $error("read data not idle");
    a_reset_quiet: assert property (disable iff (1'b0) rst |=> readData == 8'h00 && !overflowIrq)
        else $error("outputs not quiet in reset");
    a_trst_reads_zero: assert property ($past(rdSc) |-> !readData[COUNTER_RESET_BIT])
        else $error("counter reset bit read as one");
    a_irq_matches_bits: assert property ($past(rdSc) |-> (readData[7] && readData[6]) == $past(overflowIrq))
        else $error("irq differs from flag and enable");
    a_mod_clears_irq: assert property (wrMod |=> !overflowIrq)
        else $error("irq kept after modulo write");
    a_trst_clears_irq: assert property (wrSc && busRequest.writeData[COUNTER_RESET_BIT] |=> !overflowIrq)
        else $error("irq kept after counter reset");
    a_disable_drops_irq: assert property (wrSc && !busRequest.writeData[6] |=> !overflowIrq)
        else $error("irq kept after disable");
    a_irq_holds: assert property (overflowIrq && !wrSc && !wrMod |=> overflowIrq)
        else $error("irq dropped without a write");
    a_mod_read_back: assert property (wrMod ##2 rdMod |=> readData == $past(busRequest.writeData, 3))
        else $error("modulo read back wrong");
    a_cfg_read_back: assert property (wrCfg ##2 rdCfg |=> (readData & 8'h3F) == ($past(busRequest.writeData, 3) & 8'h3F))
        else $error("clock config read back wrong");
    cover property ($rose(overflowIrq));
    cover property (rdSc ##1 readData[7]);
    cover property (wrMod && overflowIrq);
endmodule

bind modulo_timer modulo_timer_monitor modulo_timer_monitor_i (.clock(clock), .rst(rst),
    .busRequest(busRequest), .readData(readData), .overflowIrq(overflowIrq));

// *** tb_modulo_timer.sv ***
// Self-checking bench of the modulo timer driven over its register port.
`timescale 1ns/100ps
module tb_modulo_timer
    import modulo_timer_pkg::*;
;
    localparam logic [7:0] SC = ADDR_TIMER_STATUS_CONTROL;
    localparam logic [7:0] CFG = ADDR_TIMER_CLOCK_CONFIG;
    localparam logic [7:0] CNT = ADDR_COUNT_VALUE;
    localparam logic [7:0] MOD = ADDR_MODULO_VALUE;
    logic clock = 1'b0;
    logic rst = 1'b1;
    bus_request_type busRequest = '0;
    timer_pins_type pins = '0;
    logic [7:0] readData;
    logic overflowIrq;
    int mismatches = 0;
    int nTests = 0;
    always #50 clock = ~clock;
    modulo_timer modulo_timer_i (.clock(clock), .rst(rst), .busRequest(busRequest), .readData(readData),
        .pins(pins), .overflowIrq(overflowIrq));
    task automatic testDone();
        if (mismatches == 0 && nTests > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
        nTests++;
        if (got !== exp)
        begin
            mismatches++;
            $display("wrong value %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clock);
        busRequest <= '{address: a, writeData: d, write: 1'b1, read: 1'b0};
        @(posedge clock);
        busRequest.write <= 1'b0;
        #1;
    endtask
    // Write data are left standing so that read-back checks can refer to them.
    task automatic rd(input logic [7:0] a, input logic [7:0] exp, input string name);
        @(posedge clock);
        busRequest.address <= a;
        busRequest.read <= 1'b1;
        @(posedge clock);
        busRequest.read <= 1'b0;
        #1;
        chk(name, exp, readData);
    endtask
    // Edges are spaced well apart because the pins pass a synchroniser before they count.
    task automatic pulse(input bit fixedSrc, input int n);
        repeat (n)
        begin
            @(posedge clock);
            if (fixedSrc)
                pins.fixedFreqClock <= 1'b1;
            else
                pins.externalTimerClockPin <= 1'b1;
            repeat (5) @(posedge clock);
            pins <= '0;
            repeat (6) @(posedge clock);
        end
        #1;
    endtask
    task automatic resetAndCheck();
        logic [7:0] exp [5] = '{8'h10, 8'h00, 8'h00, 8'h00, 8'h00};
        @(posedge clock);
        rst <= 1'b1;
        repeat (2) @(posedge clock);
        rst <= 1'b0;
        for (int i = 0; i < 5; i++)
            rd(8'(i), exp[i], "reset value");
    endtask
    initial
    begin
        repeat (20000) @(posedge clock);
        mismatches++;
        testDone();
    end
    initial
    begin
        resetAndCheck();
        wr(CFG, 8'h3F);
        rd(CFG, 8'h3F, "clock config");
        wr(CFG, 8'h30);
        pulse(0, 3);
        wr(CNT, 8'h55);
        rd(CNT, 8'h00, "stopped count");
        wr(SC, 8'h00);
        pulse(0, 5);
        rd(CNT, 8'h05, "rising pin count");
        wr(SC, 8'h10);
        pulse(0, 2);
        rd(CNT, 8'h05, "frozen count");
        wr(SC, 8'h00);
        pulse(0, 1);
        wr(CFG, 8'h20);
        pulse(0, 2);
        rd(CNT, 8'h08, "falling pin count");
        wr(CFG, 8'h10);
        pulse(1, 2);
        rd(CNT, 8'h0A, "fixed clock count");
        wr(CFG, 8'h31);
        pulse(0, 4);
        rd(CNT, 8'h0C, "divide by 2 count");
        wr(SC, 8'h10);
        wr(CFG, 8'h3F);
        wr(SC, 8'h00);
        pulse(0, 256);
        rd(CNT, 8'h0D, "divide by 256 count");
        wr(CFG, 8'h30);
        wr(MOD, 8'h03);
        rd(MOD, 8'h03, "modulo value");
        rd(CNT, 8'h00, "count after modulo write");
        pulse(0, 3);
        rd(CNT, 8'h03, "count at modulo");
        pulse(0, 1);
        rd(CNT, 8'h00, "count after wrap");
        wr(SC, 8'h00);
        rd(SC, 8'h80, "flag kept without read");
        wr(SC, 8'h00);
        rd(SC, 8'h00, "flag cleared");
        pulse(0, 4);
        rd(SC, 8'h80, "flag set again");
        pulse(0, 4);
        wr(SC, 8'h00);
        rd(SC, 8'h80, "flag after overflow in clearing");
        wr(SC, 8'h00);
        wr(SC, 8'h40);
        pulse(0, 4);
        chk("irq", 8'h01, {7'h00, overflowIrq});
        // The enable goes low with the counter reset, since it may not be written to one while the flag is set.
        wr(SC, 8'h20);
        chk("irq after counter reset", 8'h00, {7'h00, overflowIrq});
        rd(SC, 8'h00, "counter reset bit");
        rd(CNT, 8'h00, "count after counter reset");
        wr(SC, 8'h40);
        pulse(0, 4);
        wr(MOD, 8'h03);
        chk("irq after modulo write", 8'h00, {7'h00, overflowIrq});
        pulse(0, 4);
        wr(SC, 8'h00);
        chk("irq after disable", 8'h00, {7'h00, overflowIrq});
        rd(SC, 8'h80, "flag after disable");
        wr(MOD, 8'h00);
        pulse(0, 255);
        rd(CNT, 8'hFF, "free-running top");
        rd(SC, 8'h00, "no flag before wrap");
        pulse(0, 1);
        rd(SC, 8'h80, "free-running wrap flag");
        wr(CFG, 8'h00);
        wr(MOD, 8'h03);
        repeat (20) @(posedge clock);
        wr(SC, 8'h10);
        rd(SC, 8'h90, "bus clock overflow");
        wr(8'h04, 8'hFF);
        rd(8'h04, 8'h00, "unmapped address");
        resetAndCheck();
        testDone();
    end
endmodule
